/* drs_defines.svh */
// constants for the ramp and stop selection block
// How it works
// - two select inputs pick ramp pair 1..4
// - auto switching only if switch frequency nonzero
// - auto: pair 1 below, pair 4 at/above
// - assigned select inputs override auto switching
// - jog ramps: 0.1 to 6000.0 s full scale
// - jog uses jog frequency, default 6.0 Hz
// - emergency input: emergency ramp, flag indication
// - emergency held until run and input removed
// - block input turns output off, motor coasts
// - duty rating sets overload, max, stall limits
// - heavy sensorless max 150 or 100 Hz
// - light rating only in volts-per-hertz modes
// - analog polarity direct or inverse, both inputs
// - zero-speed selection has four behaviours
// - run off and below start: DC braking timed
// - range bit: 400.00 or 1200.00 Hz ceiling
// - keypad reference clamped to motor maximum
// - only preset 1 (pump) loads settings, 0 and 2..7 load none
// - pump preset loads its fixed settings
`ifndef DRS_DEFINES_SVH
`define DRS_DEFINES_SVH
// ----------------------------------------
// register indices
// ----------------------------------------
`define DRS_REG_UP_BASE 5'h00
`define DRS_REG_DOWN_BASE 5'h04
`define DRS_REG_SWITCH_FREQ 5'h08
`define DRS_REG_JOG_FREQ 5'h09
`define DRS_REG_JOG_UP 5'h0a
`define DRS_REG_JOG_DOWN 5'h0b
`define DRS_REG_EM_TIME 5'h0c
`define DRS_REG_CONFIG 5'h0d
`define DRS_REG_MOTOR_MAX 5'h0e
`define DRS_REG_DC_START 5'h0f
`define DRS_REG_DC_TIME 5'h10
`define DRS_REG_KEYPAD_REF 5'h11
`define DRS_REG_STATUS 5'h12
`define DRS_REG_EFF_MAX 5'h13
`define DRS_REG_EXTRA 5'h14
`define DRS_REG_MID_FREQ 5'h15
`define DRS_REG_MID_VOLT 5'h16
`define DRS_REG_RATE 5'h17
`define DRS_NREG 23
// ----------------------------------------
// config fields
// ----------------------------------------
`define DRS_CFG_LIGHT 0
`define DRS_CFG_INVERSE 1
`define DRS_CFG_ZERO_LO 2
`define DRS_CFG_RANGE 4
`define DRS_CFG_APP_LO 5
`define DRS_CFG_MODE_LO 8
`define DRS_CFG_LARGE 11
`define DRS_CFG_SEL_ASSIGNED 12
`define DRS_EXTRA_FWD_ONLY 0
`define DRS_EXTRA_RESTART 1
`define DRS_EXTRA_STALL_DEC 2
// ----------------------------------------
// frequencies in 0.1 Hz, times in 0.1 s
// ----------------------------------------
`define DRS_RANGE_LOW_MAX 16'h0fa0
`define DRS_RANGE_HIGH_MAX 16'h2ee0
`define DRS_LIGHT_MAX 16'h04b0
`define DRS_SLV_SMALL_MAX 16'h05dc
`define DRS_SLV_LARGE_MAX 16'h03e8
`define DRS_HEAVY_OVERLOAD 8'h96
`define DRS_LIGHT_OVERLOAD 8'h78
`define DRS_HEAVY_STALL 8'h96
`define DRS_LIGHT_STALL 8'h78
`define DRS_TIME_MIN 16'h0001
`define DRS_TIME_MAX 16'hea60
`define DRS_JOG_FREQ_RST 16'h003c
`define DRS_RAMP_RST 16'h0064
`define DRS_EM_TIME_RST 16'h0032
`define DRS_MOTOR_MAX_RST 16'h0258
`define DRS_DC_START_RST 16'h000f
`define DRS_DC_TIME_RST 16'h0005
`define DRS_ADC_FULL 12'hfff
`define DRS_APP_PUMP 3'h1
`define DRS_PUMP_RAMP 16'h000a
`define DRS_PUMP_MID_FREQ 16'h012c
`define DRS_PUMP_MID_VOLT 16'h0258
// ----------------------------------------
// timing
// ----------------------------------------
`define DRS_CLK_HZ 20000000
`define DRS_CTRL_PERIOD_US 1000
`define DRS_CTRL_TICK_CYC ((`DRS_CLK_HZ / 1000000) * `DRS_CTRL_PERIOD_US)
`define DRS_TICKS_PER_TENTH 100
`endif

/* drs_pkg.sv */
// types shared by the ramp and stop selection block
package drs_pkg;
  typedef enum logic [2:0] {
    DRS_MODE_VF,
    DRS_MODE_VF_PG,
    DRS_MODE_SENSORLESS,
    DRS_MODE_ENCODER,
    DRS_MODE_MAGNET
  } drs_mode_e;
  typedef enum logic [1:0] {
    DRS_DC_IDLE,
    DRS_DC_ARMED,
    DRS_DC_BRAKE
  } drs_dc_state_e;
  typedef logic [15:0] drs_word_t;
endpackage

/* drs_div_if.sv */
// carrier between the selector and its rate divider
`timescale 1ns/100ps
interface drs_div_if;
  logic start;
  logic [23:0] dividend;
  logic [15:0] divisor;
  logic busy;
  logic done;
  logic [23:0] quotient;
  modport requester (output start, output dividend, output divisor, input busy, input done, input quotient);
  modport server (input start, input dividend, input divisor, output busy, output done, output quotient);
endinterface

/* drs_rate_div.sv */
// serial divider computing the ramp rate
`timescale 1ns/100ps
module drs_rate_div (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // request and result
  drs_div_if.server div
);
  logic [23:0] rem_q;
  logic [23:0] quo_q;
  logic [15:0] dvs_q;
  logic [4:0] cnt;
  logic busy;
  logic done;
  wire [24:0] trial = {rem_q[23:0], quo_q[23]} - {9'h000, dvs_q};
  assign div.busy = busy;
  assign div.done = done;
  assign div.quotient = quo_q;
  // one quotient bit per clock; a zero divisor yields all ones
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= 5'h00;
      rem_q <= 24'h000000;
      quo_q <= 24'h000000;
      dvs_q <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (div.start && !busy) begin
        busy <= 1'b1;
        cnt <= 5'h18;
        rem_q <= 24'h000000;
        quo_q <= div.dividend;
        dvs_q <= div.divisor;
      end else if (busy) begin
        if (trial[24]) begin
          rem_q <= {rem_q[22:0], quo_q[23]};
          quo_q <= {quo_q[22:0], 1'b0};
        end else begin
          rem_q <= trial[23:0];
          quo_q <= {quo_q[22:0], 1'b1};
        end
        cnt <= cnt - 5'h01;
        if (cnt == 5'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // drs_rate_div

/* drs_ramp_select.sv */
// ramp pair, stop and limit selection for the drive
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "drs_defines.svh"
module drs_ramp_select #(
  parameter int CTRL_TICK_CYCLES = `DRS_CTRL_TICK_CYC,
  parameter int TICKS_PER_TENTH = `DRS_TICKS_PER_TENTH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // command terminals
  input wire logic run_cmd_i,
  input wire logic jog_i,
  input wire logic ramp_sel_lo_i,
  input wire logic ramp_sel_hi_i,
  input wire logic emergency_i,
  input wire logic output_block_i,
  // drive feedback, same clock
  input wire logic [15:0] output_freq_i,
  input wire logic [11:0] analog_input_one_i,
  input wire logic [11:0] analog_input_two_i,
  // selections out
  output logic [1:0] ramp_pair_o,
  output logic [15:0] ramp_up_o,
  output logic [15:0] ramp_down_o,
  output logic [23:0] ramp_rate_o,
  output logic [15:0] speed_ref_o,
  output logic [15:0] max_freq_o,
  output logic [7:0] overload_pct_o,
  output logic [7:0] stall_pct_o,
  output logic [11:0] analog_ref_one_o,
  output logic [11:0] analog_ref_two_o,
  output logic [1:0] zero_speed_mode_o,
  // stop handling
  output logic emergency_halt_indication_o,
  output logic run_permit_o,
  output logic output_on_o,
  output logic dc_brake_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction
  function automatic logic [15:0] time_fix(input logic [15:0] t);
    time_fix = (t < `DRS_TIME_MIN) ? `DRS_TIME_MIN : ((t > `DRS_TIME_MAX) ? `DRS_TIME_MAX : t);
  endfunction

  // ----------------------------------------
  // terminal synchronisers
  // ----------------------------------------
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else begin
      pin_meta <= {output_block_i, emergency_i, ramp_sel_hi_i, ramp_sel_lo_i, jog_i, run_cmd_i};
      pin_sync <= pin_meta;
    end
  end
  wire run_s = pin_sync[0];
  wire jog_s = pin_sync[1];
  wire sel_lo_s = pin_sync[2];
  wire sel_hi_s = pin_sync[3];
  wire em_s = pin_sync[4];
  wire block_s = pin_sync[5];

  // ----------------------------------------
  // control tick divider
  // ----------------------------------------
  logic [31:0] tick_cnt;
  logic [7:0] tenth_cnt;
  wire tick = (tick_cnt == 32'(CTRL_TICK_CYCLES - 1));
  wire tenth = tick && (tenth_cnt == 8'(TICKS_PER_TENTH - 1));
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      tick_cnt <= 32'h00000000;
      tenth_cnt <= 8'h00;
    end else begin
      tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
      if (tick) begin
        tenth_cnt <= tenth ? 8'h00 : tenth_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [15:0] regs [0:`DRS_NREG-1];
  wire [15:0] cfg = regs[`DRS_REG_CONFIG];
  wire [2:0] app_wr = reg_wdata_i[`DRS_CFG_APP_LO+:3];
  wire cfg_wr = reg_wr_i && (reg_addr_i == `DRS_REG_CONFIG);
  wire pump_load = cfg_wr && (app_wr == `DRS_APP_PUMP);
  wire wr_plain = reg_wr_i && (reg_addr_i < 5'(`DRS_NREG)) && (reg_addr_i != `DRS_REG_STATUS)
                  && (reg_addr_i != `DRS_REG_EFF_MAX) && (reg_addr_i != `DRS_REG_RATE);
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < `DRS_NREG; i++) begin
        regs[i] <= 16'h0000;
      end
      for (int i = 0; i < 8; i++) begin
        regs[i] <= `DRS_RAMP_RST;
      end
      regs[`DRS_REG_JOG_FREQ] <= `DRS_JOG_FREQ_RST;
      regs[`DRS_REG_JOG_UP] <= `DRS_RAMP_RST;
      regs[`DRS_REG_JOG_DOWN] <= `DRS_RAMP_RST;
      regs[`DRS_REG_EM_TIME] <= `DRS_EM_TIME_RST;
      regs[`DRS_REG_MOTOR_MAX] <= `DRS_MOTOR_MAX_RST;
      regs[`DRS_REG_DC_START] <= `DRS_DC_START_RST;
      regs[`DRS_REG_DC_TIME] <= `DRS_DC_TIME_RST;
    end else if (pump_load) begin
      // preset overrides the written mode and rating fields
      regs[`DRS_REG_CONFIG] <= {reg_wdata_i[15:11], 3'h0, reg_wdata_i[7:1], 1'b1};
      regs[`DRS_REG_UP_BASE] <= `DRS_PUMP_RAMP;
      regs[`DRS_REG_DOWN_BASE] <= `DRS_PUMP_RAMP;
      regs[`DRS_REG_MID_FREQ] <= `DRS_PUMP_MID_FREQ;
      regs[`DRS_REG_MID_VOLT] <= `DRS_PUMP_MID_VOLT;
      regs[`DRS_REG_EXTRA] <= 16'h0007;
    end else if (wr_plain) begin
      regs[reg_addr_i] <= reg_wdata_i;
    end
  end

  // ----------------------------------------
  // ratings and limits
  // ----------------------------------------
  wire [2:0] mode = cfg[`DRS_CFG_MODE_LO+:3];
  wire vf_mode = (mode == 3'(drs_pkg::DRS_MODE_VF)) || (mode == 3'(drs_pkg::DRS_MODE_VF_PG));
  wire light = cfg[`DRS_CFG_LIGHT] && vf_mode;
  wire [15:0] range_max = cfg[`DRS_CFG_RANGE] ? `DRS_RANGE_HIGH_MAX : `DRS_RANGE_LOW_MAX;
  wire [15:0] slv_max = cfg[`DRS_CFG_LARGE] ? `DRS_SLV_LARGE_MAX : `DRS_SLV_SMALL_MAX;
  wire [15:0] duty_max = light ? `DRS_LIGHT_MAX
                        : ((mode == 3'(drs_pkg::DRS_MODE_SENSORLESS)) ? slv_max : range_max);
  wire [15:0] next_max = min16(min16(duty_max, range_max), regs[`DRS_REG_MOTOR_MAX]);
  wire [15:0] keypad_ref = min16(regs[`DRS_REG_KEYPAD_REF], regs[`DRS_REG_MOTOR_MAX]);
  wire [15:0] jog_ref = min16(regs[`DRS_REG_JOG_FREQ], range_max);

  // ----------------------------------------
  // ramp pair choice
  // ----------------------------------------
  wire auto_on = (regs[`DRS_REG_SWITCH_FREQ] != 16'h0000);
  wire [1:0] auto_pair = (output_freq_i >= regs[`DRS_REG_SWITCH_FREQ]) ? 2'h3 : 2'h0;
  wire [1:0] next_pair = cfg[`DRS_CFG_SEL_ASSIGNED] ? {sel_hi_s, sel_lo_s}
                        : (auto_on ? auto_pair : 2'h0);
  logic [1:0] pair;
  logic em_latch;
  wire [15:0] next_up = jog_s ? time_fix(regs[`DRS_REG_JOG_UP])
                        : time_fix(regs[5'(`DRS_REG_UP_BASE + 5'(pair))]);
  wire [15:0] next_down = em_latch ? regs[`DRS_REG_EM_TIME]
                        : (jog_s ? time_fix(regs[`DRS_REG_JOG_DOWN])
                        : time_fix(regs[5'(`DRS_REG_DOWN_BASE + 5'(pair))]));

  // ----------------------------------------
  // emergency latch
  // ----------------------------------------
  wire em_clear = !run_s && !em_s;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      em_latch <= 1'b0;
    end else if (em_s) begin
      em_latch <= 1'b1;
    end else if (em_clear) begin
      em_latch <= 1'b0;
    end
  end

  // ----------------------------------------
  // rate divider
  // ----------------------------------------
  drs_div_if div_bus ();
  drs_rate_div u_div (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .div(div_bus.server)
  );
  // rate is 0.1 Hz per 0.1 s with 8 fraction bits
  assign div_bus.start = tick;
  assign div_bus.dividend = {max_freq_o, 8'h00};
  assign div_bus.divisor = (next_down == 16'h0000) ? 16'h0001 : (em_latch ? next_down : next_up);

  // ----------------------------------------
  // pair and maximum registered each control tick, the rate when the divider is done, the other selections every clock
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pair <= 2'h0;
      ramp_up_o <= `DRS_RAMP_RST;
      ramp_down_o <= `DRS_RAMP_RST;
      ramp_rate_o <= 24'h000000;
      max_freq_o <= `DRS_RANGE_LOW_MAX;
      speed_ref_o <= 16'h0000;
    end else begin
      if (tick) begin
        pair <= next_pair;
        max_freq_o <= next_max;
      end
      ramp_up_o <= next_up;
      ramp_down_o <= next_down;
      speed_ref_o <= jog_s ? jog_ref : min16(keypad_ref, max_freq_o);
      if (div_bus.done) begin
        ramp_rate_o <= div_bus.quotient;
      end
    end
  end
  assign ramp_pair_o = pair;

  // ----------------------------------------
  // analog polarity, ratings, gating
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      analog_ref_one_o <= 12'h000;
      analog_ref_two_o <= 12'h000;
      overload_pct_o <= `DRS_HEAVY_OVERLOAD;
      stall_pct_o <= `DRS_HEAVY_STALL;
      output_on_o <= 1'b0;
    end else begin
      analog_ref_one_o <= cfg[`DRS_CFG_INVERSE] ? `DRS_ADC_FULL - analog_input_one_i : analog_input_one_i;
      analog_ref_two_o <= cfg[`DRS_CFG_INVERSE] ? `DRS_ADC_FULL - analog_input_two_i : analog_input_two_i;
      overload_pct_o <= light ? `DRS_LIGHT_OVERLOAD : `DRS_HEAVY_OVERLOAD;
      stall_pct_o <= light ? `DRS_LIGHT_STALL : `DRS_HEAVY_STALL;
      output_on_o <= !block_s;
    end
  end
  assign zero_speed_mode_o = cfg[`DRS_CFG_ZERO_LO+:2];
  assign emergency_halt_indication_o = em_latch;
  assign run_permit_o = !em_latch && run_s;

  // ----------------------------------------
  // DC injection braking
  // ----------------------------------------
  drs_pkg::drs_dc_state_e dc_state;
  logic [15:0] dc_cnt;
  logic run_d;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      dc_state <= drs_pkg::DRS_DC_IDLE;
      dc_cnt <= 16'h0000;
      run_d <= 1'b0;
    end else begin
      run_d <= run_s;
      unique case (dc_state)
        drs_pkg::DRS_DC_IDLE: begin
          if (run_d && !run_s) begin
            dc_state <= drs_pkg::DRS_DC_ARMED;
          end
        end
        drs_pkg::DRS_DC_ARMED: begin
          if (run_s) begin
            dc_state <= drs_pkg::DRS_DC_IDLE;
          end else if (output_freq_i < regs[`DRS_REG_DC_START]) begin
            dc_state <= drs_pkg::DRS_DC_BRAKE;
            dc_cnt <= regs[`DRS_REG_DC_TIME];
          end
        end
        drs_pkg::DRS_DC_BRAKE: begin
          if (run_s || dc_cnt == 16'h0000) begin
            dc_state <= drs_pkg::DRS_DC_IDLE;
          end else if (tenth) begin
            dc_cnt <= dc_cnt - 16'h0001;
          end
        end
      endcase
    end
  end
  assign dc_brake_o = (dc_state == drs_pkg::DRS_DC_BRAKE) && output_on_o;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  wire [15:0] status = {9'h000, dc_brake_o, output_on_o, run_permit_o, em_latch, light, pair};
  wire [15:0] rd_mux = (reg_addr_i == `DRS_REG_STATUS) ? status
                     : (reg_addr_i == `DRS_REG_EFF_MAX) ? max_freq_o
                     : (reg_addr_i == `DRS_REG_RATE) ? ramp_rate_o[23:8]
                     : (reg_addr_i < 5'(`DRS_NREG)) ? regs[reg_addr_i] : 16'h0000;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_SEL_PAIR: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    tick && cfg[`DRS_CFG_SEL_ASSIGNED] |=> pair == $past({sel_hi_s, sel_lo_s}))
    else $error("ramp pair does not follow select inputs");
  AST_AUTO_OFF: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    tick && !cfg[`DRS_CFG_SEL_ASSIGNED] && !auto_on |=> pair == 2'h0)
    else $error("auto switching active with zero threshold");
  AST_AUTO_HIGH: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    tick && !cfg[`DRS_CFG_SEL_ASSIGNED] && auto_on && output_freq_i >= regs[`DRS_REG_SWITCH_FREQ]
    |=> pair == 2'h3)
    else $error("pair 4 not used at or above threshold");
  AST_EM_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    em_latch && (run_s || em_s) |=> em_latch)
    else $error("emergency released too early");
  AST_EM_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    em_s |=> emergency_halt_indication_o ##1 ramp_down_o == $past(regs[`DRS_REG_EM_TIME]))
    else $error("emergency not flagged or wrong stop time");
  AST_BLOCK: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    block_s |=> !output_on_o && !dc_brake_o)
    else $error("output not off under block");
  AST_LIGHT_VF: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !vf_mode |=> overload_pct_o == `DRS_HEAVY_OVERLOAD)
    else $error("light rating outside volts-per-hertz");
  AST_MAX_LIMIT: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    max_freq_o <= `DRS_RANGE_HIGH_MAX)
    else $error("maximum frequency above ceiling");
  // the maximum only moves on a tick, so judge it from the range bit of that tick
  AST_MAX_RANGE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $past(tick) && !$past(cfg[`DRS_CFG_RANGE]) |-> max_freq_o <= `DRS_RANGE_LOW_MAX)
    else $error("maximum frequency above low range ceiling");
  AST_PUMP: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    pump_load |=> regs[`DRS_REG_UP_BASE] == `DRS_PUMP_RAMP && cfg[`DRS_CFG_LIGHT] && mode == 3'h0)
    else $error("pump preset not loaded");
  AST_DC_ENTER: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    dc_state == drs_pkg::DRS_DC_ARMED && !run_s && output_freq_i < regs[`DRS_REG_DC_START]
    |=> dc_state == drs_pkg::DRS_DC_BRAKE)
    else $error("braking not entered below start frequency");
  AST_JOG_REF: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    jog_s |=> speed_ref_o == $past(jog_ref))
    else $error("jog frequency not used as reference");
  AST_INVERSE_REF: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    cfg[`DRS_CFG_INVERSE] |=> analog_ref_one_o == `DRS_ADC_FULL - $past(analog_input_one_i))
    else $error("inverse analog reference wrong");
  COV_EM: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) em_latch ##1 !em_latch);
  COV_AUTO: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) tick && auto_on ##1 pair == 2'h3);
  COV_DC: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) dc_brake_o);
  COV_RATE: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) div_bus.done);
endmodule // drs_ramp_select

/* drs_term_model.sv */
// command terminal model driving the run and stop pins
`timescale 1ns/100ps
module drs_term_model (
  // clock
  input wire logic sys_clk_i,
  // requested levels {block, emergency, sel hi, sel lo, jog, run}
  input wire logic [5:0] cmd_i,
  // terminal pins
  output logic run_cmd_o,
  output logic jog_o,
  output logic ramp_sel_lo_o,
  output logic ramp_sel_hi_o,
  output logic emergency_o,
  output logic output_block_o
);
  logic [5:0] pins = 6'h00;
  // contacts move only after an edge, never on it
  always @(posedge sys_clk_i) begin
    pins <= cmd_i;
  end
  assign {output_block_o, emergency_o, ramp_sel_hi_o, ramp_sel_lo_o, jog_o, run_cmd_o} = pins;
endmodule // drs_term_model

/* testbench.sv */
// self-checking bench for the ramp and stop selection block
`timescale 1ns/100ps
module testbench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] cmd = 6'h00;
  logic [15:0] ofreq = 16'h0000;
  logic [11:0] ain = 12'h123;
  logic [15:0] rdata, up, down, sref, maxf;
  logic [23:0] rate;
  logic [11:0] aref1, aref2;
  logic [7:0] ovl, stall;
  logic [1:0] pair, zmode;
  logic run, jog, slo, shi, em, blk, emind, permit, oon, dcb;
  logic [15:0] cfgs [6] = '{16'h0000, 16'h0010, 16'h0001, 16'h0101, 16'h0201, 16'h0a01};
  logic [15:0] maxs [6] = '{16'h0fa0, 16'h2ee0, 16'h04b0, 16'h04b0, 16'h05dc, 16'h03e8};
  logic [7:0] ovls [6] = '{8'h96, 8'h96, 8'h78, 8'h78, 8'h96, 8'h96};
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;

  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  drs_term_model i_term (.sys_clk_i(sys_clk_i), .cmd_i(cmd), .run_cmd_o(run), .jog_o(jog), .ramp_sel_lo_o(slo),
    .ramp_sel_hi_o(shi), .emergency_o(em), .output_block_o(blk));

  // short ticks keep the run brief
  drs_ramp_select #(.CTRL_TICK_CYCLES(10), .TICKS_PER_TENTH(2)) i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .run_cmd_i(run),
    .jog_i(jog), .ramp_sel_lo_i(slo), .ramp_sel_hi_i(shi), .emergency_i(em), .output_block_i(blk),
    .output_freq_i(ofreq), .analog_input_one_i(ain), .analog_input_two_i(ain ^ 12'h0f0), .ramp_pair_o(pair),
    .ramp_up_o(up), .ramp_down_o(down), .ramp_rate_o(rate), .speed_ref_o(sref), .max_freq_o(maxf),
    .overload_pct_o(ovl), .stall_pct_o(stall), .analog_ref_one_o(aref1), .analog_ref_two_o(aref2),
    .zero_speed_mode_o(zmode), .emergency_halt_indication_o(emind), .run_permit_o(permit), .output_on_o(oon),
    .dc_brake_o(dcb));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    @(negedge sys_clk_i);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  // pins pass a model flop and two sync flops, then wait for a tick
  task automatic term(input logic [5:0] c);
    @(posedge sys_clk_i);
    cmd <= c;
    repeat (30) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  task automatic settle;
    repeat (60) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rd_reg(5'h09, 16'h003c);
    rd_reg(5'h0c, 16'h0032);
    rd_reg(5'h1f, 16'h0000);
    wr_reg(5'h0e, 16'h2ee0);
    wr_reg(5'h08, 16'h0064);
    wr_reg(5'h0d, 16'h1000);
    for (int i = 0; i < 4; i++) begin
      wr_reg(5'(i), 16'h0100 + 16'(i));
      wr_reg(5'(i + 4), 16'h0200 + 16'(i));
    end
    ofreq <= 16'h0200;
    for (int p = 0; p < 4; p++) begin
      term({2'b00, 2'(p), 2'b00});
      chk(pair, 24'(p));
      chk(up, 24'h000100 + 24'(p));
      chk(down, 24'h000200 + 24'(p));
      // the divider runs once per three ticks, so give it time to pick up the new pair
      settle();
      chk(rate, (24'h000fa0 * 24'd256) / (24'h000100 + 24'(p)));
    end
    term(6'h00);
    wr_reg(5'h0d, 16'h0000);
    ofreq <= 16'h0063;
    settle();
    chk(pair, 24'h0);
    @(posedge sys_clk_i);
    ofreq <= 16'h0064;
    settle();
    chk(pair, 24'h3);
    wr_reg(5'h08, 16'h0000);
    settle();
    chk(pair, 24'h0);
    for (int k = 0; k < 6; k++) begin
      wr_reg(5'h0d, cfgs[k]);
      settle();
      chk(maxf, maxs[k]);
      chk(ovl, ovls[k]);
      chk(stall, ovls[k]);
    end
    wr_reg(5'h0d, 16'h0002);
    settle();
    chk(aref1, 12'hfff - ain);
    chk(aref2, 12'hfff - (ain ^ 12'h0f0));
    for (int z = 0; z < 4; z++) begin
      wr_reg(5'h0d, 16'(z) << 2);
      settle();
      chk(zmode, 24'(z));
      chk(aref1, ain);
    end
    wr_reg(5'h0e, 16'h0258);
    wr_reg(5'h11, 16'hffff);
    settle();
    chk(sref, 24'h000258);
    wr_reg(5'h0a, 16'h0033);
    term(6'h02);
    chk(sref, 24'h00003c);
    chk(up, 24'h000033);
    term(6'h20);
    chk(oon, 1'b0);
    term(6'h00);
    chk(oon, 1'b1);
    term(6'h01);
    chk(permit, 1'b1);
    term(6'h11);
    chk(emind, 1'b1);
    chk(permit, 1'b0);
    chk(down, 24'h000032);
    term(6'h01);
    chk(emind, 1'b1);
    term(6'h00);
    chk(emind, 1'b0);
    term(6'h01);
    chk(permit, 1'b1);
    @(posedge sys_clk_i);
    ofreq <= 16'h0100;
    term(6'h00);
    chk(dcb, 1'b0);
    @(posedge sys_clk_i);
    ofreq <= 16'h0000;
    repeat (10) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(dcb, 1'b1);
    // five tenths of 20 cycles each: still braking after 80 cycles
    repeat (70) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(dcb, 1'b1);
    repeat (80) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(dcb, 1'b0);
    wr_reg(5'h0d, 16'h0020);
    rd_reg(5'h00, 16'h000a);
    rd_reg(5'h04, 16'h000a);
    rd_reg(5'h15, 16'h012c);
    rd_reg(5'h16, 16'h0258);
    rd_reg(5'h14, 16'h0007);
    rd_reg(5'h0d, 16'h0021);
    wr_reg(5'h13, 16'h0000);
    settle();
    rd_reg(5'h13, 16'h0258);
    close_out();
  end
endmodule // testbench
